// >>> rtl/fdc_aux_defines.svh
`ifndef FDC_AUX_DEFINES_SVH
`define FDC_AUX_DEFINES_SVH
`define PORT_COUNT 3'h6
`define OFF_CMD_STATUS 3'h0
`define OFF_TRACK 3'h1
`define OFF_SECTOR 3'h2
`define OFF_DATA 3'h3
`define OFF_AUX 3'h4
`define OFF_WAIT 3'h5
`define BASE_HI 7
`define BASE_LO 3
`define CTL_RESET 8'h00
`define BIT_DMA_WRITE 7
`define BIT_DMA_EN 6
`define BIT_PRECOMP 5
`define BIT_SMALL 4
`define BIT_DDEN 3
`define BIT_SIDE 2
`define BIT_PICK_HI 1
`define BIT_PICK_LO 0
`define ST_CHANGE 7
`define ST_TWO_SIDED 6
`define ST_HEAD 5
`define ST_IRQ 0
`define ST_UNDEF 4'h0
`endif

// >>> rtl/fdc_aux_pkg.sv
package fdc_aux_pkg;
  typedef enum logic [1:0] {idle_s, wait_s, done_s} wait_state_t;
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] rdata;
    logic rvalid;
    logic bus_wait;
    wait_state_t ws;
    logic ctrl_cs;
    logic ctrl_rd;
    logic ctrl_wr;
    logic [1:0] ctrl_reg;
    logic [7:0] ctrl_wdata;
  } aux_state_t;
endpackage

// >>> rtl/drive_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "fdc_aux_defines.svh"
module drive_select (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control byte and jumper
  input wire logic [7:0] ctl,
  input wire logic precomp_auto,
  input wire logic outer_track_flag,
  input wire logic ctrl_head_load,
  // drive lines
  output logic [3:0] large_sel,
  output logic [3:0] small_sel,
  output logic side_sel,
  output logic double_density,
  output logic precomp_en,
  output logic low_current,
  output logic restore,
  output logic head_load
);
  typedef struct packed {
    logic [3:0] large_sel;
    logic [3:0] small_sel;
    logic side_sel;
    logic double_density;
    logic precomp_en;
    logic low_current;
    logic restore;
    logic head_load;
  } sel_t;
  sel_t s_q, s_d;

  function automatic logic [3:0] one_hot(input logic [1:0] code);
    one_hot = 4'h1 << code;
  endfunction

  always_comb begin
    logic [3:0] pick;
    logic rst_fn;
    logic pc;
    pick = one_hot({ctl[`BIT_PICK_HI], ctl[`BIT_PICK_LO]});
    rst_fn = ~ctl[`BIT_DMA_EN] & ctl[`BIT_DMA_WRITE];
    pc = precomp_auto ? outer_track_flag : ctl[`BIT_PRECOMP];
    s_d = s_q;
    s_d.large_sel = ctl[`BIT_SMALL] ? 4'h0 : pick;
    s_d.small_sel = ctl[`BIT_SMALL] ? pick : 4'h0;
    s_d.side_sel = ctl[`BIT_SIDE];
    s_d.double_density = ctl[`BIT_DDEN];
    s_d.precomp_en = pc & ctl[`BIT_DDEN];
    s_d.low_current = pc;
    s_d.restore = rst_fn;
    s_d.head_load = ctrl_head_load | rst_fn;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign large_sel = s_q.large_sel;
  assign small_sel = s_q.small_sel;
  assign side_sel = s_q.side_sel;
  assign double_density = s_q.double_density;
  assign precomp_en = s_q.precomp_en;
  assign low_current = s_q.low_current;
  assign restore = s_q.restore;
  assign head_load = s_q.head_load;
endmodule // drive_select
`default_nettype wire

// >>> rtl/floppy_board_aux_ports.sv
`timescale 1ns/1ps
`default_nettype none
`include "fdc_aux_defines.svh"
module floppy_board_aux_ports (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // host i/o bus
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic io_rd,
  input wire logic io_wr,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic bus_wait,
  // board switches and jumpers
  input wire logic [4:0] base_switch,
  input wire logic precomp_auto,
  // controller chip port
  output logic ctrl_cs,
  output logic ctrl_rd,
  output logic ctrl_wr,
  output logic [1:0] ctrl_reg,
  output logic [7:0] ctrl_wdata,
  input wire logic [7:0] ctrl_rdata,
  input wire logic ctrl_irq,
  input wire logic ctrl_drq,
  input wire logic ctrl_head_load,
  input wire logic outer_track_flag,
  // dma
  output logic dma_req,
  output logic dma_write,
  input wire logic dma_cycle,
  output logic dma_ack,
  // drive side
  input wire logic disk_changed_n,
  input wire logic two_sided,
  output logic [3:0] large_sel,
  output logic [3:0] small_sel,
  output logic side_sel,
  output logic double_density,
  output logic precomp_en,
  output logic low_current,
  output logic restore,
  output logic head_load
);
  fdc_aux_pkg::aux_state_t st_q, st_d;
  logic dma_req_q, dma_write_q, dma_ack_q;

  // board-level match on the 8-port block, offsets 0..5 only
  function automatic logic port_hit(input logic [7:0] a, input logic [4:0] sw);
    port_hit = (a[`BASE_HI:`BASE_LO] == sw) && (a[2:0] < `PORT_COUNT);
  endfunction

  function automatic logic [7:0] aux_status(input logic chg_n, input logic ts,
      input logic hl, input logic irq);
    aux_status = {chg_n, ts, hl, `ST_UNDEF, irq};
  endfunction

  always_comb begin
    logic hit;
    logic [2:0] off;
    logic aux_acc;
    hit = port_hit(addr, base_switch);
    off = addr[2:0];
    aux_acc = hit && (off == `OFF_AUX || off == `OFF_WAIT);
    st_d = st_q;
    st_d.rvalid = 1'b0;
    st_d.ctrl_cs = 1'b0;
    st_d.ctrl_rd = 1'b0;
    st_d.ctrl_wr = 1'b0;
    case (st_q.ws)
      fdc_aux_pkg::idle_s: begin
        if (hit && (io_rd || io_wr)) begin
          if (off == `OFF_WAIT && !(ctrl_irq || ctrl_drq)) begin
            st_d.ws = fdc_aux_pkg::wait_s;
            st_d.bus_wait = 1'b1;
          end else if (aux_acc) begin
            if (io_wr) begin
              st_d.ctl = wdata;
            end
            st_d.rdata = aux_status(disk_changed_n, two_sided, head_load, ctrl_irq);
            st_d.rvalid = io_rd;
            st_d.ws = fdc_aux_pkg::done_s;
          end else begin
            // controller clears its irq/drq on these strobes
            st_d.ctrl_cs = 1'b1;
            st_d.ctrl_rd = io_rd;
            st_d.ctrl_wr = io_wr;
            st_d.ctrl_reg = off[1:0];
            st_d.ctrl_wdata = wdata;
            st_d.ws = fdc_aux_pkg::done_s;
          end
        end
      end
      fdc_aux_pkg::wait_s: begin
        if (ctrl_irq || ctrl_drq) begin
          st_d.bus_wait = 1'b0;
          if (io_wr) begin
            st_d.ctl = wdata;
          end
          st_d.rdata = aux_status(disk_changed_n, two_sided, head_load, ctrl_irq);
          st_d.rvalid = io_rd;
          st_d.ws = fdc_aux_pkg::done_s;
        end
      end
      fdc_aux_pkg::done_s: begin
        if (st_q.ctrl_rd) begin
          st_d.rdata = ctrl_rdata;
          st_d.rvalid = 1'b1;
        end
        if (!io_rd && !io_wr) begin
          st_d.ws = fdc_aux_pkg::idle_s;
        end
      end
      default: st_d.ws = fdc_aux_pkg::idle_s;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
      st_q.ctl <= `CTL_RESET;
      st_q.ws <= fdc_aux_pkg::idle_s;
      dma_req_q <= 1'b0;
      dma_write_q <= 1'b0;
      dma_ack_q <= 1'b0;
    end else begin
      st_q <= st_d;
      dma_req_q <= st_q.ctl[`BIT_DMA_EN] & ctrl_drq;
      dma_ack_q <= st_q.ctl[`BIT_DMA_EN] & dma_cycle;
      dma_write_q <= st_q.ctl[`BIT_DMA_WRITE];
    end
  end

  drive_select u_sel (
    .clk(clk),
    .nrst(nrst),
    .ctl(st_q.ctl),
    .precomp_auto(precomp_auto),
    .outer_track_flag(outer_track_flag),
    .ctrl_head_load(ctrl_head_load),
    .large_sel(large_sel),
    .small_sel(small_sel),
    .side_sel(side_sel),
    .double_density(double_density),
    .precomp_en(precomp_en),
    .low_current(low_current),
    .restore(restore),
    .head_load(head_load)
  );

  assign rdata = st_q.rdata;
  assign rvalid = st_q.rvalid;
  assign bus_wait = st_q.bus_wait;
  assign ctrl_cs = st_q.ctrl_cs;
  assign ctrl_rd = st_q.ctrl_rd;
  assign ctrl_wr = st_q.ctrl_wr;
  assign ctrl_reg = st_q.ctrl_reg;
  assign ctrl_wdata = st_q.ctrl_wdata;
  assign dma_req = dma_req_q;
  assign dma_write = dma_write_q;
  assign dma_ack = dma_ack_q;
endmodule // floppy_board_aux_ports
`default_nettype wire

// >>> tb/aux_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module aux_checker (
  // clock and reset
  input wire logic clk, nrst,
  // watched ports
  input wire logic bus_wait, ctrl_cs, ctrl_rd, ctrl_irq, ctrl_drq, restore, head_load,
  input wire logic dma_req, dma_write, dma_cycle, dma_ack, precomp_en, double_density,
  input wire logic [3:0] large_sel, small_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_dma_req_gate: assert property (dma_req |-> $past(ctrl_drq)) else $error("stray dma req");
  a_dma_ack_gate: assert property (dma_ack |-> $past(dma_cycle)) else $error("stray ack");
  a_one_drive: assert property ($onehot0({large_sel, small_sel})) else $error("bad select");
  a_restore_dir: assert property (restore |-> dma_write) else $error("restore bad");
  a_restore_head: assert property (restore |-> head_load) else $error("head idle");
  a_precomp_dd: assert property (precomp_en |-> double_density) else $error("precomp sd");
  a_wait_hold: assert property (bus_wait && !ctrl_irq && !ctrl_drq |=> bus_wait)
    else $error("wait dropped early");
  a_wait_end: assert property (bus_wait && (ctrl_irq || ctrl_drq) |=> !bus_wait)
    else $error("wait stuck");
  a_rd_strobe: assert property (ctrl_rd |-> ctrl_cs ##1 !ctrl_cs) else $error("strobe");
endmodule // aux_checker
bind floppy_board_aux_ports aux_checker chk_u (.*);
`default_nettype wire

// >>> tb/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  // bus answer
  input wire logic clk, rvalid, bus_wait,
  input wire logic [7:0] rdata,
  // bus request
  output logic [7:0] addr = 8'h00, wdata = 8'h00,
  output logic io_rd = 1'b0, io_wr = 1'b0
);
  // holds the request until answered or for at most 40 clock edges, then drops it at that edge
  task automatic acc(input logic [7:0] a, d, input logic r, output logic [7:0] q,
      output logic ok);
    ok = 1'b0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    io_rd <= r;
    io_wr <= !r;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge clk);
      ok = r ? rvalid : (i > 1 && !bus_wait);
    end
    q = rdata;
    io_rd <= 1'b0;
    io_wr <= 1'b0;
  endtask
endmodule // host_bus_model
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, nrst = 1'b0, ok;
  logic [4:0] base_switch = 5'h15;
  logic [7:0] addr, wdata, rdata, ctrl_wdata, q, ctrl_rdata = 8'h5A;
  logic [7:0] tab [5] = '{8'h1D, 8'h6A, 8'hC6, 8'h00, 8'h83};
  logic [3:0] large_sel, small_sel;
  logic [1:0] ctrl_reg;
  logic io_rd, io_wr, rvalid, bus_wait, ctrl_cs, ctrl_rd, ctrl_wr, dma_req, dma_write, dma_ack;
  logic side_sel, double_density, precomp_en, low_current, restore, head_load;
  logic precomp_auto = 1'b0, ctrl_irq = 1'b0, ctrl_drq = 1'b1, ctrl_head_load = 1'b0;
  logic outer_track_flag = 1'b0, dma_cycle = 1'b1, disk_changed_n = 1'b1, two_sided = 1'b0;
  int err_count = 0, compares = 0;
  always #2.5 clk = ~clk;
  floppy_board_aux_ports dut_u (.*);
  host_bus_model host_u (.clk, .rvalid, .bus_wait, .rdata, .addr, .wdata, .io_rd, .io_wr);
  // latches the last controller write strobe with its select, register and data
  logic [10:0] wr_seen = 11'h000;
  always @(posedge clk) begin
    if (ctrl_wr) begin
      wr_seen <= {ctrl_cs, ctrl_reg, ctrl_wdata};
    end
  end
  task automatic chk(input logic [7:0] got, exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_aux(input logic [7:0] a, b);
    logic [3:0] s;
    s = 4'h1 << b[1:0];
    host_u.acc(a, b, 1'b0, q, ok);
    @(posedge clk);
    chk({large_sel, small_sel}, b[4] ? {4'h0, s} : {s, 4'h0});
    chk({dma_write, side_sel, double_density, precomp_en, restore, head_load, low_current, 1'b0},
      {b[7], b[2], b[3], b[5] & b[3], b[7] & !b[6], b[7] & !b[6], b[5], 1'b0});
    chk({6'h0, dma_req, dma_ack}, {6'h0, b[6], b[6]});
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk({large_sel, small_sel}, 8'h10);
    chk({dma_write, restore, dma_req, side_sel, double_density, precomp_en, 2'h0}, 8'h00);
    $display("reset test done");
    foreach (tab[i]) begin
      wr_aux(8'hAC + 8'(i % 2), tab[i]);
    end
    $display("control tests done");
    disk_changed_n <= 1'b0;
    two_sided <= 1'b1;
    ctrl_irq <= 1'b1;
    host_u.acc(8'hAC, 8'h00, 1'b1, q, ok);
    chk(q, 8'h61);
    host_u.acc(8'hAD, 8'h00, 1'b1, q, ok);
    chk(q, 8'h61);
    disk_changed_n <= 1'b1;
    two_sided <= 1'b0;
    ctrl_irq <= 1'b0;
    ctrl_drq <= 1'b0;
    fork
      host_u.acc(8'hAD, 8'h00, 1'b1, q, ok);
      begin
        repeat (5) @(posedge clk);
        chk({7'h0, bus_wait}, 8'h01);
        ctrl_irq <= 1'b1;
      end
    join
    chk(q, 8'hA1);
    $display("status tests done");
    host_u.acc(8'hAB, 8'h00, 1'b1, q, ok);
    chk(q, 8'h5A);
    host_u.acc(8'hA8, 8'hD0, 1'b0, q, ok);
    chk(wr_seen[7:0], 8'hD0);
    chk({5'h0, wr_seen[10:8]}, 8'h04);
    host_u.acc(8'hAE, 8'h00, 1'b1, q, ok);
    chk({7'h0, ok}, 8'h00);
    host_u.acc(8'h2C, 8'h00, 1'b1, q, ok);
    chk({7'h0, ok}, 8'h00);
    $display("port decode tests done");
    precomp_auto <= 1'b1;
    outer_track_flag <= 1'b1;
    host_u.acc(8'hAC, 8'h08, 1'b0, q, ok);
    @(posedge clk);
    chk({6'h0, precomp_en, low_current}, 8'h03);
    outer_track_flag <= 1'b0;
    host_u.acc(8'hAC, 8'h28, 1'b0, q, ok);
    @(posedge clk);
    chk({6'h0, precomp_en, low_current}, 8'h00);
    $display("precomp test done");
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
